// >>> hw/adc_fmt_pkg.sv
// constants, register map and types for the converter configuration block
`default_nettype none
package adc_fmt_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CONFIG_OFS = 8'h04;
   localparam logic [7:0] RES_HIGH_OFS = 8'h08;
   localparam logic [7:0] RES_LOW_OFS = 8'h0C;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
   localparam logic [7:0] IRQ_CLEAR_OFS = 8'h14;
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h18;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int EN_BIT = 0;
   localparam int GO_BIT = 1;
   localparam int CHAN_LSB = 2;
   localparam int CHAN_MSB = 6;
   localparam int FMT_BIT = 7;
   localparam int CLK_LSB = 4;
   localparam int CLK_MSB = 6;
   localparam int NREF_BIT = 2;
   localparam int PREF_LSB = 0;
   localparam int PREF_MSB = 1;
   localparam int DONE_IRQ_BIT = 0;
   // ------------------------------------------------------------
   // values after reset and codes
   // ------------------------------------------------------------
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [1:0] CLK_RC_LOW = 2'h3;
   localparam logic [3:0] CONV_TADS = 4'hB;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } conv_state_e;
endpackage : adc_fmt_pkg
`default_nettype wire

// >>> hw/adc_clk_div.sv
// conversion clock enable: divided system clock or dedicated rc oscillator
`default_nettype none
module adc_clk_div (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [2:0] clk_sel,
   input wire logic rc_edge,
   output logic tick
);
   import adc_fmt_pkg::*;

   // ------------------------------------------------------------
   // divide ratio per code, zero for the rc codes
   // ------------------------------------------------------------
   function automatic logic [6:0] div_ratio(input logic [2:0] sel);
      case (sel)
         3'h0: div_ratio = 7'h02;
         3'h4: div_ratio = 7'h04;
         3'h1: div_ratio = 7'h08;
         3'h5: div_ratio = 7'h10;
         3'h2: div_ratio = 7'h20;
         3'h6: div_ratio = 7'h40;
         default: div_ratio = 7'h00;
      endcase
   endfunction

   logic is_rc;
   logic [6:0] cnt_reg;
   logic [6:0] ratio;
   assign is_rc = (clk_sel[1:0] == CLK_RC_LOW);
   assign ratio = div_ratio(clk_sel);

   always_ff @(posedge sys_clk) begin
      if (rst || !run) begin
         cnt_reg <= 7'h00;
         tick <= 1'b0;
      end else if (is_rc) begin
         cnt_reg <= 7'h00;
         tick <= rc_edge;
      end else if (cnt_reg >= ratio - 7'h01) begin
         cnt_reg <= 7'h00;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 7'h01;
         tick <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [6:0] gap_reg;
   logic seen_reg;
   logic [2:0] sel_q;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gap_reg <= 7'h00;
         seen_reg <= 1'b0;
         sel_q <= 3'h0;
      end else begin
         sel_q <= clk_sel;
         gap_reg <= tick ? 7'h00 : gap_reg + 7'h01;
         if (!run || clk_sel != sel_q) begin
            seen_reg <= 1'b0;
         end else if (tick) begin
            seen_reg <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_div_gap;
      tick && seen_reg && run && !is_rc && clk_sel == sel_q |-> gap_reg == ratio - 7'h01;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("divided tick spacing wrong");

   property p_rc_tick;
      tick && $past(is_rc) |-> $past(rc_edge);
   endproperty
   a_rc_tick: assert property (p_rc_tick) else $error("rc tick without rc edge");
endmodule // adc_clk_div
`default_nettype wire

// >>> hw/adc_config_format.sv
// converter control, configuration and result formatting behind an ahb-lite slave
`default_nettype none
// Contract
// - format 1 loads right justified: high byte top six bits zero, low byte bits 7..0.
// - format 0 loads left justified: low byte bottom six zero, high byte bits 9..2.
// - clock field bits 6..4 divide system clock by 2,4,8,16,32,64 per code.
// - codes 011 and 111 select the dedicated rc oscillator as conversion clock.
// - negative reference bit 2: 0 ground, 1 external negative reference pin.
// - positive reference field: 00 supply, 10 external pin, 11 fixed reference, 01 reserved.
// - left justified high register holds the eight most significant result bits.
// - left justified low register holds result bits 1..0 in bits 7..6.
// - right justified high register holds result bits 9..8 in bits 1..0.
// - right justified low register holds the eight least significant result bits.
// - writing go starts conversion; go stays set while converting, clears at completion.
// - enable bit powers the converter; cleared means disabled, no operating current.
// - channel field bits 6..2 routes the selected analog input to the converter.
module adc_config_format (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [9:0] sample_data,
   input wire logic rc_osc_clk,
   output logic converter_enable,
   output logic [4:0] channel_select,
   output logic [1:0] pos_ref_select,
   output logic neg_ref_select,
   output logic rc_osc_enable,
   output logic hold_capacitor,
   output logic irq
);
   import adc_fmt_pkg::*;
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [9:0] samp_s1_reg;
   logic [9:0] samp_s2_reg;
   logic rc_s1_reg;
   logic rc_s2_reg;
   logic rc_s3_reg;
   logic rc_edge;
   // sampled value held steady by software acquisition wait
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         samp_s1_reg <= 10'h000;
         samp_s2_reg <= 10'h000;
         rc_s1_reg <= 1'b0;
         rc_s2_reg <= 1'b0;
         rc_s3_reg <= 1'b0;
      end else begin
         samp_s1_reg <= sample_data;
         samp_s2_reg <= samp_s1_reg;
         rc_s1_reg <= rc_osc_clk;
         rc_s2_reg <= rc_s1_reg;
         rc_s3_reg <= rc_s2_reg;
      end
   end
   assign rc_edge = rc_s2_reg & ~rc_s3_reg;
   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   logic ap_take;
   logic dp_valid_reg;
   logic dp_write_reg;
   logic dp_word_reg;
   logic [7:0] dp_addr_reg;
   logic rd_wait_reg;
   logic wr_en;
   assign ap_take = hsel & hready & htrans[1];
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_word_reg <= 1'b0;
         dp_addr_reg <= BYTE_RESET;
      end else if (hready) begin
         dp_valid_reg <= ap_take;
         dp_write_reg <= hwrite;
         dp_word_reg <= (hsize == HSIZE_WORD);
         dp_addr_reg <= haddr;
      end
   end
   // reads take one wait state so a write just before is seen
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_wait_reg <= 1'b0;
      end else if (rd_wait_reg) begin
         rd_wait_reg <= 1'b0;
      end else begin
         rd_wait_reg <= ap_take & ~hwrite;
      end
   end
   assign hreadyout = ~rd_wait_reg;
   assign hresp = 1'b0;
   assign wr_en = dp_valid_reg & dp_write_reg & dp_word_reg;
   logic wr_ctrl;
   logic wr_config;
   logic wr_res_hi;
   logic wr_res_lo;
   logic wr_clear;
   logic wr_irq_en;
   assign wr_ctrl = wr_en & hit(dp_addr_reg, CTRL_OFS);
   assign wr_config = wr_en & hit(dp_addr_reg, CONFIG_OFS);
   assign wr_res_hi = wr_en & hit(dp_addr_reg, RES_HIGH_OFS);
   assign wr_res_lo = wr_en & hit(dp_addr_reg, RES_LOW_OFS);
   assign wr_clear = wr_en & hit(dp_addr_reg, IRQ_CLEAR_OFS);
   assign wr_irq_en = wr_en & hit(dp_addr_reg, IRQ_ENABLE_OFS);
   // ------------------------------------------------------------
   // control and configuration registers
   // ------------------------------------------------------------
   logic en_reg;
   logic go_reg;
   logic [4:0] chan_reg;
   logic fmt_reg;
   logic [2:0] clk_sel_reg;
   logic nref_reg;
   logic [1:0] pref_reg;
   logic done;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         en_reg <= 1'b0;
         chan_reg <= 5'h00;
      end else if (wr_ctrl) begin
         en_reg <= hwdata[EN_BIT];
         chan_reg <= hwdata[CHAN_MSB:CHAN_LSB];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         go_reg <= 1'b0;
      end else if (wr_ctrl) begin
         go_reg <= hwdata[GO_BIT] & hwdata[EN_BIT];
      end else if (done || !en_reg) begin
         go_reg <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fmt_reg <= 1'b0;
         clk_sel_reg <= 3'h0;
         nref_reg <= 1'b0;
         pref_reg <= 2'h0;
      end else if (wr_config) begin
         fmt_reg <= hwdata[FMT_BIT];
         clk_sel_reg <= hwdata[CLK_MSB:CLK_LSB];
         nref_reg <= hwdata[NREF_BIT];
         pref_reg <= hwdata[PREF_MSB:PREF_LSB];
      end
   end

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   conv_state_e state_reg;
   logic [3:0] tad_reg;
   logic [9:0] held_reg;
   logic tick;
   logic busy;
   assign busy = (state_reg == ST_CONV);
   assign done = busy & go_reg & tick & (tad_reg == CONV_TADS - 4'h1) & ~wr_ctrl;
   adc_clk_div u_clk_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(busy),
      .clk_sel(clk_sel_reg),
      .rc_edge(rc_edge),
      .tick(tick)
   );
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         tad_reg <= 4'h0;
         held_reg <= 10'h000;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               tad_reg <= 4'h0;
               if (go_reg) begin
                  state_reg <= ST_CONV;
                  held_reg <= samp_s2_reg;
               end
            end
            ST_CONV: begin
               if (!go_reg || done) begin
                  state_reg <= ST_IDLE;
               end else if (tick) begin
                  tad_reg <= tad_reg + 4'h1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // result registers, formatted at load
   // ------------------------------------------------------------
   logic [7:0] res_hi_reg;
   logic [7:0] res_lo_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         res_hi_reg <= BYTE_RESET;
         res_lo_reg <= BYTE_RESET;
      end else if (done) begin
         if (fmt_reg) begin
            res_hi_reg <= {6'h00, held_reg[9:8]};
            res_lo_reg <= held_reg[7:0];
         end else begin
            res_hi_reg <= held_reg[9:2];
            res_lo_reg <= {held_reg[1:0], 6'h00};
         end
      end else begin
         if (wr_res_hi) begin
            res_hi_reg <= hwdata[7:0];
         end
         if (wr_res_lo) begin
            res_lo_reg <= hwdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   logic [7:0] status_reg;
   logic [7:0] irq_en_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         status_reg <= BYTE_RESET;
         irq_en_reg <= BYTE_RESET;
         irq <= 1'b0;
      end else begin
         // completion wins over a clear in the same cycle
         status_reg[DONE_IRQ_BIT] <= done | (status_reg[DONE_IRQ_BIT] & ~(wr_clear & hwdata[DONE_IRQ_BIT]));
         if (wr_irq_en) begin
            irq_en_reg <= {7'h00, hwdata[DONE_IRQ_BIT]};
         end
         irq <= |(status_reg & irq_en_reg);
      end
   end

   // ------------------------------------------------------------
   // read data and outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hrdata <= WORD_ZERO;
      end else if (rd_wait_reg) begin
         case (dp_addr_reg)
            CTRL_OFS: hrdata <= {24'h00_0000, 1'b0, chan_reg, go_reg, en_reg};
            CONFIG_OFS: hrdata <= {24'h00_0000, fmt_reg, clk_sel_reg, 1'b0, nref_reg, pref_reg};
            RES_HIGH_OFS: hrdata <= {24'h00_0000, res_hi_reg};
            RES_LOW_OFS: hrdata <= {24'h00_0000, res_lo_reg};
            IRQ_STATUS_OFS: hrdata <= {24'h00_0000, status_reg};
            IRQ_ENABLE_OFS: hrdata <= {24'h00_0000, irq_en_reg};
            default: hrdata <= WORD_ZERO;
         endcase
      end
   end

   assign converter_enable = en_reg;
   assign channel_select = chan_reg;
   assign pos_ref_select = pref_reg;
   assign neg_ref_select = nref_reg;
   assign rc_osc_enable = en_reg & (clk_sel_reg[1:0] == CLK_RC_LOW);
   assign hold_capacitor = busy;
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_load_right;
      done && fmt_reg;
   endsequence
   sequence s_load_left;
      done && !fmt_reg;
   endsequence
   property p_right;
      s_load_right |=> res_hi_reg == {6'h00, $past(held_reg[9:8])} && res_lo_reg == $past(held_reg[7:0]);
   endproperty
   a_right: assert property (p_right) else $error("right justified load wrong");
   property p_left;
      s_load_left |=> res_hi_reg == $past(held_reg[9:2]) && res_lo_reg == {$past(held_reg[1:0]), 6'h00};
   endproperty
   a_left: assert property (p_left) else $error("left justified load wrong");
   property p_refs;
      wr_config |=> pos_ref_select == $past(hwdata[1:0]) && neg_ref_select == $past(hwdata[2]);
   endproperty
   a_refs: assert property (p_refs) else $error("reference selection not taken");
   property p_chan;
      wr_ctrl |=> channel_select == $past(hwdata[6:2]) && converter_enable == $past(hwdata[0]);
   endproperty
   a_chan: assert property (p_chan) else $error("channel or enable not taken");
   sequence s_start;
      !busy && $rose(go_reg);
   endsequence
   property p_start;
      s_start |=> busy && go_reg;
   endproperty
   a_start: assert property (p_start) else $error("go did not start a conversion");
   property p_done;
      done |=> !go_reg && !busy && status_reg[DONE_IRQ_BIT];
   endproperty
   a_done: assert property (p_done) else $error("completion did not clear go");
   property p_busy_go;
      busy |-> go_reg || $past(go_reg);
   endproperty
   a_busy_go: assert property (p_busy_go) else $error("busy without go");
   property p_off;
      !en_reg && !wr_ctrl |=> !go_reg ##1 !busy;
   endproperty
   a_off: assert property (p_off) else $error("disabled converter still running");
   property p_keep;
      !done && !wr_res_hi && !wr_res_lo |=> $stable(res_hi_reg) && $stable(res_lo_reg);
   endproperty
   a_keep: assert property (p_keep) else $error("stored result changed without load");
   property p_set_wins;
      done && wr_clear && hwdata[DONE_IRQ_BIT] |=> status_reg[DONE_IRQ_BIT] ##1 irq == irq_en_reg[DONE_IRQ_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("completion lost to clear");
   property p_read_wait;
      ap_take && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
endmodule // adc_config_format
`default_nettype wire

// >>> sim/analog_src_model.sv
// stand-in for the analog side: channel level source and dedicated rc oscillator
`default_nettype none
module analog_src_model (
   input wire logic converter_enable,
   input wire logic rc_osc_enable,
   input wire logic [9:0] level,
   output logic [9:0] sample_data,
   output var logic rc_osc_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   // unpowered converter sees the inverse, never the level
   assign sample_data = converter_enable ? level : ~level;
   // rc oscillator runs only while requested, free of the system clock phase
   initial begin
      rc_osc_clk = 1'b0;
   end
   always begin
      #20.3;
      rc_osc_clk = rc_osc_enable ? ~rc_osc_clk : 1'b0;
   end
endmodule // analog_src_model
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the converter configuration and result block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_fmt_pkg::*;
   typedef struct packed {
      logic fmt;
      logic [2:0] code;
      logic [9:0] lvl;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [6:0] ratio;
   } row_s;
   // ------------------------------------------------------------
   // signals and design
   // ------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = WORD_ZERO;
   logic [9:0] level = 10'h000;
   logic hreadyout, hresp, irq, converter_enable, neg_ref_select, rc_osc_enable, hold_capacitor, rc_osc_clk;
   logic [31:0] hrdata;
   logic [9:0] sample_data;
   logic [4:0] channel_select;
   logic [1:0] pos_ref_select;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int hold_len = 0;
   row_s rows [8] = '{
      '{1'b0, 3'h0, 10'h3A5, 8'hE9, 8'h40, 7'd2},
      '{1'b1, 3'h4, 10'h3A5, 8'h03, 8'hA5, 7'd4},
      '{1'b0, 3'h1, 10'h15A, 8'h56, 8'h80, 7'd8},
      '{1'b1, 3'h5, 10'h15A, 8'h01, 8'h5A, 7'd16},
      '{1'b0, 3'h2, 10'h3FF, 8'hFF, 8'hC0, 7'd32},
      '{1'b1, 3'h6, 10'h3FF, 8'h03, 8'hFF, 7'd64},
      '{1'b1, 3'h3, 10'h000, 8'h00, 8'h00, 7'd0},
      '{1'b0, 3'h7, 10'h15A, 8'h56, 8'h80, 7'd0}};
   always #4 sys_clk = ~sys_clk;
   adc_config_format i_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .sample_data(sample_data), .rc_osc_clk(rc_osc_clk),
      .converter_enable(converter_enable), .channel_select(channel_select), .pos_ref_select(pos_ref_select),
      .neg_ref_select(neg_ref_select), .rc_osc_enable(rc_osc_enable), .hold_capacitor(hold_capacitor),
      .irq(irq));
   analog_src_model i_src (.converter_enable(converter_enable), .rc_osc_enable(rc_osc_enable),
      .level(level), .sample_data(sample_data), .rc_osc_clk(rc_osc_clk));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (hold_capacitor === 1'b1) begin
         hold_len <= hold_len + 1;
      end
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %0t run too long", $time);
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_len(input int got, input int exp, input int tol);
      num_checks++;
      if (got < exp - tol || got > exp + tol) begin
         bad_count++;
         $display("[FAIL] %0t conversion length %0d exp %0d", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      logic ok;
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ_BIT;
      haddr <= a;
      hwrite <= wr;
      ok = 1'b0;
      while (!ok) begin
         @(negedge sys_clk);
         ok = (hreadyout === 1'b1);
         @(posedge sys_clk);
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      ok = 1'b0;
      while (!ok) begin
         @(negedge sys_clk);
         ok = (hreadyout === 1'b1);
         q = hrdata;
         @(posedge sys_clk);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, {24'h00_0000, d}, q);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [31:0] q;
      bus(1'b0, a, WORD_ZERO, q);
      chk(q, {24'h00_0000, exp}, what);
   endtask
   task automatic convert(input logic [4:0] ch);
      int n;
      wr(CTRL_OFS, {1'b0, ch, 2'b01});
      repeat (20) @(posedge sys_clk); // acquisition interval after channel change
      hold_len <= 0;
      wr(CTRL_OFS, {1'b0, ch, 2'b11});
      for (n = 0; n < 1500 && !(n > 3 && hold_capacitor === 1'b0); n++) begin
         @(negedge sys_clk);
      end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] cfg;
      logic [4:0] ch;
      logic [1:0] pref;
      int i;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      wr(IRQ_ENABLE_OFS, 8'h01);
      for (i = 0; i < 8; i++) begin
         pref = (i % 3 == 0) ? 2'b00 : ((i % 3 == 1) ? 2'b10 : 2'b11);
         ch = (i == 6) ? 5'h1E : ((i == 7) ? 5'h1F : 5'(i));
         cfg = {rows[i].fmt, rows[i].code, 1'b0, i[0], pref};
         wr(CONFIG_OFS, cfg);
         level <= rows[i].lvl;
         rdchk(CONFIG_OFS, cfg, "config");
         chk(32'(pos_ref_select), 32'(pref), "pos ref");
         chk(32'(neg_ref_select), 32'(i[0]), "neg ref");
         convert(ch);
         chk(32'(channel_select), 32'(ch), "channel");
         chk(32'(converter_enable), 32'h0000_0001, "enable");
         chk(32'(rc_osc_enable), 32'(rows[i].ratio == 0), "rc select");
         chk_len(hold_len, (rows[i].ratio == 0) ? 56 : 11 * rows[i].ratio + 1, 8 * (rows[i].ratio == 0));
         rdchk(RES_HIGH_OFS, rows[i].hi, "result high");
         rdchk(RES_LOW_OFS, rows[i].lo, "result low");
         rdchk(CTRL_OFS, {1'b0, ch, 2'b01}, "go cleared");
         rdchk(IRQ_STATUS_OFS, 8'h01, "done status");
         chk(32'(irq), 32'h0000_0001, "irq raised");
         wr(IRQ_CLEAR_OFS, 8'h01);
         repeat (2) @(negedge sys_clk);
         chk(32'(irq), 32'h0000_0000, "irq cleared");
      end
      // stored left justified result survives a format change
      wr(CONFIG_OFS, 8'hF0);
      rdchk(RES_HIGH_OFS, 8'h56, "kept high");
      rdchk(RES_LOW_OFS, 8'h80, "kept low");
      wr(RES_LOW_OFS, 8'h3C);
      rdchk(RES_LOW_OFS, 8'h3C, "result write");
      // go reads set while converting, then abort leaves no status
      wr(CONFIG_OFS, 8'h60);
      // channel kept from the last row, so no new acquisition is owed
      wr(CTRL_OFS, 8'h7F);
      rdchk(CTRL_OFS, 8'h7F, "go busy");
      wr(CTRL_OFS, 8'h7D);
      repeat (4) @(negedge sys_clk);
      chk(32'(hold_capacitor), 32'h0000_0000, "abort hold");
      rdchk(IRQ_STATUS_OFS, 8'h00, "abort status");
      // go with converter off is ignored
      wr(CTRL_OFS, 8'h02);
      repeat (4) @(negedge sys_clk);
      chk(32'(hold_capacitor), 32'h0000_0000, "go while off");
      chk(32'(converter_enable), 32'h0000_0000, "off");
      rdchk(CTRL_OFS, 8'h00, "ctrl off");
      // masked interrupt
      wr(IRQ_ENABLE_OFS, 8'h00);
      wr(CONFIG_OFS, 8'h00);
      convert(5'h03);
      rdchk(IRQ_STATUS_OFS, 8'h01, "masked status");
      chk(32'(irq), 32'h0000_0000, "masked irq");
      wr(IRQ_ENABLE_OFS, 8'h01);
      repeat (2) @(negedge sys_clk);
      chk(32'(irq), 32'h0000_0001, "unmasked irq");
      // clear lands in the completing cycle of a divide-by-2 run: completion wins
      wr(IRQ_CLEAR_OFS, 8'h01);
      wr(CTRL_OFS, 8'h0F);
      repeat (21) @(posedge sys_clk);
      wr(IRQ_CLEAR_OFS, 8'h01);
      rdchk(IRQ_STATUS_OFS, 8'h01, "set wins");
      // unmapped and unimplemented places
      wr(8'h1C, 8'hFF);
      rdchk(8'h1C, 8'h00, "unmapped");
      wr(CONFIG_OFS, 8'hFF);
      rdchk(CONFIG_OFS, 8'hF7, "config bit 3");
      // second reset after the last conversion has finished clears every field
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (rows[k]) begin
         if (k < 5) begin
            rdchk(8'(k * 4), 8'h00, "reset value");
         end
      end
      chk(32'(irq), 32'h0000_0000, "reset irq");
      chk(32'({converter_enable, pos_ref_select, neg_ref_select, hresp}), WORD_ZERO, "reset outputs");
      test_done();
   end
endmodule // tb_top
`default_nettype wire
